/* File: design/eox_defines.svh */
`ifndef EOX_DEFINES_SVH
`define EOX_DEFINES_SVH
// register indices, byte address is four times the index
`define EOX_IDX_TS0_NAT 12'h054
`define EOX_IDX_SPARE 12'h055
`define EOX_IDX_SA4 12'h056
`define EOX_IDX_SA5 12'h057
`define EOX_IDX_SA6 12'h058
`define EOX_IDX_SA7 12'h059
`define EOX_IDX_SA8 12'h05a
`define EOX_IDX_PFLAGS 12'h05b
`define EOX_IDX_CTRL 12'h05c
`define EOX_IDX_CHG 12'h05d
`define EOX_IDX_PMASK 12'h062
// control register fields
`define EOX_CTRL_SEL_BIT 7
`define EOX_CTRL_DEB_BIT 6
// pattern flag positions
`define EOX_PF_FFF 4
`define EOX_PF_EEE 3
`define EOX_PF_CCC 2
`define EOX_PF_AAA 1
`define EOX_PF_888 0
// patterns
`define EOX_PAT_FFF 12'hfff
`define EOX_PAT_EEE 12'heee
`define EOX_PAT_CCC 12'hccc
`define EOX_PAT_AAA 12'haaa
`define EOX_PAT_888 12'h888
// counts
`define EOX_NFAS_PER_SUBMF 3'h4
`define EOX_WIN_BITS 4'hc
`define EOX_WIN_WORDS 2'h3
// reset values
`define EOX_RST_BYTE 8'h00
`define EOX_RST_NIB 4'h0
`endif

/* File: design/eox_pkg.sv */
package eox_pkg;
    // one national bit codeword
    typedef logic [3:0] eox_nib_t;
    // events and levels from the frame aligner, same clock
    typedef struct packed {
        logic bfa_ok;
        logic cmfa_ok;
        logic smfa_ok;
        logic nfas_stb;
        logic [7:0] ts0_octet;
        logic cas_f0_stb;
        logic [7:0] ts16_octet;
        logic smf_first;
        logic submf_first;
    } eox_fr_s;
    // avalon request
    typedef struct packed {
        logic [13:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } eox_av_req_s;
endpackage

/* File: design/eox_overhead_rx.sv */
// Design decision made here: the Avalon-MM slave port.
`include "eox_defines.svh"
// What this block does
// - remote alarm bit latched per NFAS, held unaligned
// - Sa4-Sa8 latched per NFAS, frozen unaligned
// - extra bits into bits 3,1,0 each multiframe
// - remote multiframe alarm into bit 2
// - per-position 4-bit codeword, bit one at 3
// - debounce: update after two equal codewords
// - no debounce: update every sub-multiframe
// - codewords frozen while CRC multiframe lost
// - flag all-ones window 0xFFF
// - flag window 0xEEE
// - flag window 0xCCC
// - flag window 0xAAA
// - flag window 0x888
// - select bits or codewords, only when aligned
// - control bit 6 enables debounce
module eox_overhead_rx (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // frame aligner
    input eox_pkg::eox_fr_s fr,
    // avalon-mm slave
    input eox_pkg::eox_av_req_s av,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // interrupt
    output logic irq
);

////////////////////////////////////////////////////////////////////////
// bus decode

logic wait_r;
logic [31:0] rdata_r;
logic irq_r;
wire req = av.read | av.write;
wire [11:0] idx = av.address[13:2];
wire aligned = (av.address[1:0] == 2'b00);
wire wr_do = av.write & ~wait_r & aligned;
wire [7:0] wbyte = av.writedata[7:0];
wire wr_ctrl = wr_do & (idx == `EOX_IDX_CTRL);
wire wr_pmask = wr_do & (idx == `EOX_IDX_PMASK);
wire wr_pflag = wr_do & (idx == `EOX_IDX_PFLAGS);
wire wr_chg = wr_do & (idx == `EOX_IDX_CHG);

////////////////////////////////////////////////////////////////////////
// control registers

logic [7:0] ctrl;
logic [4:0] pmask;
wire sel_words = ctrl[`EOX_CTRL_SEL_BIT];
wire deb_en = ctrl[`EOX_CTRL_DEB_BIT];

// software writable controls
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        ctrl <= `EOX_RST_BYTE;
        pmask <= 5'h00;
    end else begin
        if (wr_ctrl) begin
            ctrl <= wbyte;
        end
        if (wr_pmask) begin
            pmask <= wbyte[4:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// NFAS remote alarm and national bits

logic alarm_a;
logic [4:0] nat_bits;
wire nfas_take = fr.nfas_stb & fr.bfa_ok;

// capture at NFAS boundary, hold while unaligned
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        alarm_a <= 1'b0;
        nat_bits <= 5'h00;
    end else if (nfas_take) begin
        alarm_a <= fr.ts0_octet[5];
        nat_bits <= fr.ts0_octet[4:0];
    end
end

////////////////////////////////////////////////////////////////////////
// signalling multiframe spare bits

logic [3:0] spare_pend;
logic [3:0] spare;

// octet holds X0,Y,X1,X2 in its low nibble
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        spare_pend <= `EOX_RST_NIB;
        spare <= `EOX_RST_NIB;
    end else if (fr.smfa_ok) begin
        if (fr.cas_f0_stb) begin
            spare_pend <= fr.ts16_octet[3:0];
        end
        if (fr.smf_first) begin
            spare[3] <= spare_pend[3];
            spare[1:0] <= spare_pend[1:0];
            spare[2] <= spare_pend[2];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// sub-multiframe bookkeeping

logic [2:0] nfas_cnt;
wire cw_ready = fr.submf_first & fr.cmfa_ok & (nfas_cnt == `EOX_NFAS_PER_SUBMF);

// count NFAS frames within the current sub-multiframe
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        nfas_cnt <= 3'h0;
    end else if (fr.submf_first | ~fr.cmfa_ok) begin
        nfas_cnt <= 3'h0;
    end else if (nfas_take && nfas_cnt != `EOX_NFAS_PER_SUBMF) begin
        nfas_cnt <= nfas_cnt + 3'h1;
    end
end

////////////////////////////////////////////////////////////////////////
// codeword assembly, one lane per national bit

eox_pkg::eox_nib_t cw_out [5];
eox_pkg::eox_nib_t cw_raw [5];
logic [4:0] chg_set;

genvar g;
generate
    for (g = 0; g < 5; g++) begin : lane
        eox_pkg::eox_nib_t shr;
        eox_pkg::eox_nib_t prev;
        eox_pkg::eox_nib_t outw;
        // lane g sits at octet bit 4-g
        wire take_new = cw_ready & (~deb_en | (shr == prev));
        assign cw_out[g] = outw;
        assign cw_raw[g] = shr;
        assign chg_set[4-g] = take_new & (shr != outw);
        // first received bit shifts up to bit 3
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                shr <= `EOX_RST_NIB;
                prev <= `EOX_RST_NIB;
                outw <= `EOX_RST_NIB;
            end else begin
                if (nfas_take && fr.cmfa_ok) begin
                    shr <= {shr[2:0], fr.ts0_octet[4-g]};
                end
                if (cw_ready) begin
                    prev <= shr;
                end
                if (take_new) begin
                    outw <= shr;
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// Sa6 pattern windows

logic [11:0] bit_win;
logic [3:0] bit_fill;
logic [11:0] word_win;
logic [1:0] word_fill;
logic cmp_bits_stb;
logic cmp_words_stb;

// window fill counts cleared whenever CRC multiframe is lost, window contents kept
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        bit_win <= 12'h000;
        bit_fill <= 4'h0;
        word_win <= 12'h000;
        word_fill <= 2'h0;
        cmp_bits_stb <= 1'b0;
        cmp_words_stb <= 1'b0;
    end else if (!fr.cmfa_ok) begin
        bit_fill <= 4'h0;
        word_fill <= 2'h0;
        cmp_bits_stb <= 1'b0;
        cmp_words_stb <= 1'b0;
    end else begin
        cmp_bits_stb <= nfas_take & ~sel_words & (bit_fill >= 4'hb);
        cmp_words_stb <= cw_ready & sel_words & (word_fill >= 2'h2);
        if (nfas_take) begin
            bit_win <= {bit_win[10:0], fr.ts0_octet[2]};
            if (bit_fill != `EOX_WIN_BITS) begin
                bit_fill <= bit_fill + 4'h1;
            end
        end
        if (cw_ready) begin
            word_win <= {word_win[7:0], cw_raw[2]};
            if (word_fill != `EOX_WIN_WORDS) begin
                word_fill <= word_fill + 2'h1;
            end
        end
    end
end

// compare the selected window
wire cmp_stb = (sel_words ? cmp_words_stb : cmp_bits_stb) & fr.cmfa_ok;
wire [11:0] win = sel_words ? word_win : bit_win;
logic [4:0] hit;
assign hit[`EOX_PF_FFF] = cmp_stb & (win == `EOX_PAT_FFF);
assign hit[`EOX_PF_EEE] = cmp_stb & (win == `EOX_PAT_EEE);
assign hit[`EOX_PF_CCC] = cmp_stb & (win == `EOX_PAT_CCC);
assign hit[`EOX_PF_AAA] = cmp_stb & (win == `EOX_PAT_AAA);
assign hit[`EOX_PF_888] = cmp_stb & (win == `EOX_PAT_888);

////////////////////////////////////////////////////////////////////////
// sticky status, set wins over clear

logic [4:0] pflags;
logic [4:0] chg;
wire [4:0] next_pflags = (pflags & ~(wr_pflag ? wbyte[4:0] : 5'h00)) | hit;
wire [4:0] next_chg = (chg & ~(wr_chg ? wbyte[4:0] : 5'h00)) | chg_set;

// pattern and change flags
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        pflags <= 5'h00;
        chg <= 5'h00;
    end else begin
        pflags <= next_pflags;
        chg <= next_chg;
    end
end

////////////////////////////////////////////////////////////////////////
// read mux

logic [7:0] rmux;
always_comb begin
    rmux = `EOX_RST_BYTE;
    if (aligned) begin
        unique case (idx)
            `EOX_IDX_TS0_NAT: rmux = {2'b00, alarm_a, nat_bits};
            `EOX_IDX_SPARE: rmux = {4'h0, spare};
            `EOX_IDX_SA4: rmux = {4'h0, cw_out[0]};
            `EOX_IDX_SA5: rmux = {4'h0, cw_out[1]};
            `EOX_IDX_SA6: rmux = {4'h0, cw_out[2]};
            `EOX_IDX_SA7: rmux = {4'h0, cw_out[3]};
            `EOX_IDX_SA8: rmux = {4'h0, cw_out[4]};
            `EOX_IDX_PFLAGS: rmux = {3'h0, pflags};
            `EOX_IDX_CTRL: rmux = ctrl;
            `EOX_IDX_CHG: rmux = {3'h0, chg};
            `EOX_IDX_PMASK: rmux = {3'h0, pmask};
            default: rmux = `EOX_RST_BYTE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// bus answer and interrupt

// masks are taken at their next value so a mask write moves irq at the same edge as a flag write
wire [4:0] next_pmask = wr_pmask ? wbyte[4:0] : pmask;
wire [4:0] next_chg_mask = wr_ctrl ? wbyte[4:0] : ctrl[4:0];
wire next_irq = (|(next_pflags & next_pmask)) | (|(next_chg & next_chg_mask));

// one wait cycle then answer
always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        wait_r <= 1'b1;
        rdata_r <= 32'h0000_0000;
        irq_r <= 1'b0;
    end else begin
        wait_r <= ~(req & wait_r);
        irq_r <= next_irq;
        if (av.read && wait_r) begin
            rdata_r <= {24'h00_0000, rmux};
        end
    end
end

assign av_readdata = rdata_r;
assign av_waitrequest = wait_r;
assign irq = irq_r;

endmodule

/* File: tb/eox_overhead_rx_chk.sv */
module eox_overhead_rx_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // watched ports
    input eox_pkg::eox_fr_s fr,
    input eox_pkg::eox_av_req_s av,
    input wire logic [31:0] av_readdata,
    input wire logic av_waitrequest,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    ////////////////
    // bus answer timing and read data
    a_wait_one: assert property ((av.read || av.write) && av_waitrequest |=> !av_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_short: assert property (!av_waitrequest |=> av_waitrequest)
        else $error("answer held too long");
    a_rd_hold: assert property (!(av.read && av_waitrequest) |=> $stable(av_readdata))
        else $error("read data moved without a read");
    a_rd_misalign: assert property (av.read && av_waitrequest && av.address[1:0] != 2'b00
        |=> av_readdata == 32'h0000_0000) else $error("misaligned read not zero");
    a_nat_si: assert property (av.read && av_waitrequest && av.address == 14'h0150
        |=> av_readdata[31:6] == 26'h000_0000) else $error("national read upper bits set");
    a_cw_upper: assert property (av.read && av_waitrequest && av.address >= 14'h0154
        && av.address <= 14'h0168 |=> av_readdata[31:4] == 28'h000_0000) else $error("codeword upper bits set");
    // interrupt only moves for a cause
    a_irq_fall: assert property ($fell(irq) |-> $past(av.write && !av_waitrequest))
        else $error("irq fell without a write");
    a_irq_rise: assert property ($rose(irq) |-> $past(fr.nfas_stb, 2) || $past(fr.submf_first)
        || $past(fr.submf_first, 2) || $past(av.write && !av_waitrequest)) else $error("irq rose without a cause");
endmodule
bind eox_overhead_rx eox_overhead_rx_chk i_chk (.clock(clock), .rst_b(rst_b), .fr(fr), .av(av),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .irq(irq));

/* File: tb/eox_framer_mdl.sv */
module eox_framer_mdl (
    // clock
    input wire logic clock,
    // framer outputs
    output eox_pkg::eox_fr_s fr
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle framer
    initial fr = '0;
    // one strobe cycle, data lines inverted once released
    task stb(input logic [3:0] k, input logic [7:0] d);
        @(posedge clock);
        {fr.nfas_stb, fr.cas_f0_stb, fr.smf_first, fr.submf_first} <= k;
        fr.ts0_octet <= d;
        fr.ts16_octet <= d;
        @(posedge clock);
        {fr.nfas_stb, fr.cas_f0_stb, fr.smf_first, fr.submf_first} <= 4'h0;
        fr.ts0_octet <= ~d;
        fr.ts16_octet <= ~d;
    endtask
    // alignment levels: basic, crc, signalling
    task lv(input logic [2:0] l);
        @(posedge clock);
        {fr.bfa_ok, fr.cmfa_ok, fr.smfa_ok} <= l;
    endtask
endmodule

/* File: tb/eox_overhead_rx_tb.sv */
module eox_overhead_rx_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    eox_pkg::eox_fr_s fr;
    eox_pkg::eox_av_req_s av = '0;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    logic irq;
    logic [31:0] q;
    int miscompares = 0;
    int checked = 0;
    logic [11:0] pat [5] = '{12'hfff, 12'heee, 12'hccc, 12'haaa, 12'h888};
    ////////////////
    // clock
    always #12.5 clock = ~clock;
    // design and far side
    eox_overhead_rx i_dut (.clock(clock), .rst_b(rst_b), .fr(fr), .av(av), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .irq(irq));
    eox_framer_mdl i_frm (.clock(clock), .fr(fr));
    ////////////////
    task close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] v, input logic [31:0] e);
        checked++;
        if (v !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", s, e, v);
        end
    endtask
    // one avalon cycle: raised after an edge, held to the edge that sees waitrequest low
    task bus(input logic [13:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        av <= '{a, !w, w, {~d, d, ~d, d}};
        do @(posedge clock); while (av_waitrequest !== 1'b0 && ++n < 50);
        if (av_waitrequest !== 1'b0) miscompares++;
        q = av_readdata;
        av.read <= 1'b0;
        av.write <= 1'b0;
        @(posedge clock);
    endtask
    // irq is registered, so look one edge after its cause
    task irq_is(input logic e);
        @(posedge clock);
        chk("irq", irq, 32'(e));
    endtask
    task rd(input logic [13:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk($sformatf("reg %h", a), q, {24'h0000_00, e});
    endtask
    // four nfas frames carrying five codewords, optional closing strobe
    task sub(input logic [19:0] w, input bit cl);
        logic [7:0] o;
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 5; j++) o[j] = w[j*4+3-k];
            o[7:5] = 3'b000;
            i_frm.stb(4'h8, o);
        end
        if (cl) i_frm.stb(4'h1, 8'h00);
    endtask
    task cw(input logic [19:0] w);
        for (int j = 0; j < 5; j++) rd(14'h0158 + 14'(4 * j), {4'h0, w[19-4*j -: 4]});
    endtask
    ////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out;
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rd(14'h0150 + 14'(4 * i), 8'h00);
        rd(14'h01fc, 8'h00);
        rd(14'h0155, 8'h00);
        bus(14'h0154, 1'b1, 8'hff);
        rd(14'h0154, 8'h00);
        i_frm.lv(3'b111);
        i_frm.stb(4'h8, 8'hff);
        rd(14'h0150, 8'h3f);
        i_frm.stb(4'h4, 8'hfa);
        i_frm.stb(4'h2, 8'h00);
        rd(14'h0154, 8'h0a);
        i_frm.lv(3'b010);
        i_frm.stb(4'h8, 8'h00);
        i_frm.stb(4'h4, 8'h05);
        i_frm.stb(4'h2, 8'h00);
        rd(14'h0150, 8'h3f);
        rd(14'h0154, 8'h0a);
        i_frm.lv(3'b110);
        bus(14'h0170, 1'b1, 8'h1f);
        bus(14'h0171, 1'b1, 8'hff);
        rd(14'h0170, 8'h1f);
        i_frm.stb(4'h1, 8'h00);
        sub(20'h1_2345, 1'b1);
        cw(20'h1_2345);
        bus(14'h0170, 1'b1, 8'h5f);
        sub(20'h6_789a, 1'b1);
        cw(20'h1_2345);
        sub(20'h6_789a, 1'b1);
        cw(20'h6_789a);
        i_frm.lv(3'b100);
        sub(20'hb_bbbb, 1'b1);
        cw(20'h6_789a);
        bus(14'h0170, 1'b1, 8'h1f);
        bus(14'h0174, 1'b1, 8'h1f);
        bus(14'h016c, 1'b1, 8'hff);
        irq_is(1'b0);
        // each pattern over twelve bits, window fill counts cleared by alignment loss
        for (int i = 0; i < 5; i++) begin
            i_frm.lv(3'b100);
            i_frm.lv(3'b110);
            for (int b = 0; b < 12; b++) i_frm.stb(4'h8, {5'h00, pat[i][11-b], 2'b00});
            @(posedge clock);
            rd(14'h016c, 8'h10 >> i);
            irq_is(1'b0);
            bus(14'h0188, 1'b1, 8'h1f);
            irq_is(1'b1);
            bus(14'h0188, 1'b1, 8'h00);
            irq_is(1'b0);
            i_frm.stb(4'h8, 8'h00);
            rd(14'h016c, 8'h10 >> i);
            bus(14'h016c, 1'b1, 8'hff);
            rd(14'h016c, 8'h00);
        end
        // word mode: no flag before the third codeword closes
        bus(14'h0170, 1'b1, 8'h9f);
        i_frm.lv(3'b100);
        i_frm.lv(3'b110);
        i_frm.stb(4'h1, 8'h00);
        sub(20'h0_0e00, 1'b1);
        sub(20'h0_0e00, 1'b1);
        sub(20'h0_0e00, 1'b0);
        rd(14'h016c, 8'h00);
        i_frm.stb(4'h1, 8'h00);
        @(posedge clock);
        rd(14'h016c, 8'h08);
        close_out;
    end
endmodule
